// file: pss_power_state_sequencer.v
// power state sequencer: off, deep sleep, sleep, wakeup and on states
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.vh"
// Operation
// - power-down pin low forces off, all cleared
// - deep sleep powers only clock domain
// - retention memory keeps contents in deep sleep
// - sleep runs clock logic, oscillator off
// - any wakeup event moves sleep to wakeup
// - wakeup state enables oscillator and plls
// - wakeup advances to on once clocks ready
// - on state gates clock per enable bit
// - wait instruction gates only cpu clock
module pss_power_state_sequencer (
  input wire CORE_CLK,
  input wire RESET,
  input wire POWER_DOWN_PIN_N,
  input wire WAKE_MAC,
  input wire WAKE_HOST,
  input wire WAKE_RTC_TIMER,
  input wire WAKE_EXT_INT,
  input wire SLEEP_REQ,
  input wire DEEP_SLEEP_REQ,
  input wire [`PSS_NBLK-1:0] CLK_CTRL,
  input wire WAIT_FOR_INTERRUPT_INSTR,
  input wire CPU_IRQ,
  input wire CLOCKS_LOCKED,
  input wire RET_WE,
  input wire [`PSS_RET_AW-1:0] RET_ADDR,
  input wire [`PSS_RET_DW-1:0] RET_WDATA,
  output reg [`PSS_RET_DW-1:0] RET_RDATA,
  output reg [2:0] POWER_STATE,
  output reg RTC_DOMAIN_EN,
  output reg MAIN_POWER_EN,
  output reg XTAL_EN,
  output reg PLL_EN,
  output reg HS_CLK_RUN,
  output reg [`PSS_NBLK-1:0] BLK_CLK_EN,
  output reg CPU_CLK_EN
);
  // synchroniser stages for asynchronous pins
  // bit 0 power-down pin, bits 1 to 4 wake sources, bit 5 clock lock
  reg [5:0] sync1_ff; // first stage, read only by the second
  reg [5:0] sync2_ff; // second stage, safe to use
  // synchronised views of the pins
  wire pd_n_s = sync2_ff[0]; // pin level, low means off
  wire wake_any = |sync2_ff[4:1]; // any of the four wake sources
  wire locked_s = sync2_ff[5]; // oscillator and plls locked
  // state, settle counter, cpu wait latch
  reg [2:0] state_ff; // current power state
  reg [2:0] nxt_state; // state for the next edge
  reg [7:0] settle_ff; // cycles left before on may be entered
  reg cpu_wait_ff; // cpu parked by the wait instruction
  reg [`PSS_NBLK-1:0] clk_ctrl_ff; // registered clock control enables
  // state decodes shared by the output registers
  wire st_off = (state_ff == `PSS_ST_OFF); // pin held low
  wire st_sleep = (state_ff == `PSS_ST_SLEEP); // oscillator stopped
  wire st_wake = (state_ff == `PSS_ST_WAKE); // clocks starting
  wire st_on = (state_ff == `PSS_ST_ON); // fully powered
  // retention memory, not cleared except by power-down
  // the array has no reset; the valid flag hides stale words
  reg [`PSS_RET_DW-1:0] ret_mem [0:`PSS_RET_DEPTH-1]; // kept in always-on domain
  reg ret_valid_ff; // set by the first write since off
  // loop index for the per block gates
  genvar blk_idx;

  // two-flop synchronisers
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else begin
      sync1_ff <= {CLOCKS_LOCKED, WAKE_EXT_INT, WAKE_RTC_TIMER, WAKE_HOST, WAKE_MAC,
        POWER_DOWN_PIN_N};
      sync2_ff <= sync1_ff;
    end
  end

  // next state selection
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `PSS_ST_OFF: begin
        // leave off once pin released
        if (pd_n_s)
          nxt_state = `PSS_ST_WAKE;
      end
      `PSS_ST_DEEP, `PSS_ST_SLEEP: begin
        // any wake source restarts clocks
        if (wake_any)
          nxt_state = `PSS_ST_WAKE;
      end
      `PSS_ST_WAKE: begin
        // clocks settled and locked
        if (locked_s && settle_ff == 8'h00)
          nxt_state = `PSS_ST_ON;
      end
      `PSS_ST_ON: begin
        // deep sleep has priority over sleep
        if (DEEP_SLEEP_REQ)
          nxt_state = `PSS_ST_DEEP;
        else if (SLEEP_REQ)
          nxt_state = `PSS_ST_SLEEP;
      end
      default: begin
        // illegal codes fall back to off
        nxt_state = `PSS_ST_OFF;
      end
    endcase
    // pin low overrides everything
    if (!pd_n_s)
      nxt_state = `PSS_ST_OFF;
  end

  // state, settle counter and cpu wait registers
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      // off with a full settle count
      state_ff <= `PSS_ST_OFF;
      settle_ff <= `PSS_SETTLE_CYC;
      cpu_wait_ff <= 1'b0;
      clk_ctrl_ff <= {`PSS_NBLK{1'b0}};
    end else begin
      // advance to the selected state
      state_ff <= nxt_state;
      // enables cleared whenever off is entered
      clk_ctrl_ff <= (nxt_state == `PSS_ST_OFF) ? {`PSS_NBLK{1'b0}} : CLK_CTRL;
      // count down while waking, reload elsewhere
      if (st_wake && settle_ff != 8'h00)
        // one more cycle of settling done
        settle_ff <= settle_ff - 8'h01;
      else if (!st_wake)
        // full wait again on the next wakeup
        settle_ff <= `PSS_SETTLE_CYC;
      // wait instruction sets, interrupt clears
      if (!st_on)
        // leaving on releases the cpu
        cpu_wait_ff <= 1'b0;
      else if (CPU_IRQ)
        // interrupt wins over the wait instruction
        cpu_wait_ff <= 1'b0;
      else if (WAIT_FOR_INTERRUPT_INSTR)
        // park the cpu until an interrupt
        cpu_wait_ff <= 1'b1;
    end
  end

  // output registers follow the current state one cycle later
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      // everything dark while reset is held
      POWER_STATE <= `PSS_ST_OFF;
      RTC_DOMAIN_EN <= 1'b0;
      MAIN_POWER_EN <= 1'b0;
      XTAL_EN <= 1'b0;
      PLL_EN <= 1'b0;
      HS_CLK_RUN <= 1'b0;
      CPU_CLK_EN <= 1'b0;
    end else begin
      // state shown to the outside
      POWER_STATE <= state_ff;
      // always-on domain is dark only while off
      RTC_DOMAIN_EN <= !st_off;
      // deep sleep keeps only the always-on domain
      MAIN_POWER_EN <= st_wake || st_on || st_sleep;
      // oscillator stopped in both sleep states
      XTAL_EN <= st_wake || st_on;
      // plls start together with the oscillator
      PLL_EN <= st_wake || st_on;
      // high-speed clock runs only when fully on
      HS_CLK_RUN <= st_on;
      // cpu clock parked while waiting for an interrupt
      CPU_CLK_EN <= st_on && !cpu_wait_ff;
    end
  end

  // per block clock gates, one flop per enable bit
  generate
    for (blk_idx = 0; blk_idx < `PSS_NBLK; blk_idx = blk_idx + 1) begin : g_blk_gate
      // gate closed outside on and while the bit is clear
      always @(posedge CORE_CLK) begin
        if (RESET)
          BLK_CLK_EN[blk_idx] <= 1'b0;
        else
          BLK_CLK_EN[blk_idx] <= st_on && clk_ctrl_ff[blk_idx];
      end
    end
  endgenerate

  // retention memory: writable when on, kept through sleep states
  // writes outside on are refused
  always @(posedge CORE_CLK) begin
    if (st_on && RET_WE)
      // address and word taken at the same edge
      ret_mem[RET_ADDR] <= RET_WDATA;
  end

  // contents valid until power-down pin clears them
  always @(posedge CORE_CLK) begin
    if (RESET || state_ff == `PSS_ST_OFF)
      ret_valid_ff <= 1'b0;
    else if (state_ff == `PSS_ST_ON && RET_WE)
      ret_valid_ff <= 1'b1;
  end

  // read port, zero when not valid
  always @(posedge CORE_CLK) begin
    if (RESET)
      RET_RDATA <= {`PSS_RET_DW{1'b0}};
    else if (ret_valid_ff)
      // word survives both sleep states
      RET_RDATA <= ret_mem[RET_ADDR];
    else
      // stale words hidden until the first write since off
      RET_RDATA <= {`PSS_RET_DW{1'b0}};
  end
endmodule // pss_power_state_sequencer
`default_nettype wire

// file: pss_consts.vh
// constants for the power state sequencer
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH
// power state encodings
`define PSS_ST_OFF 3'h0
`define PSS_ST_DEEP 3'h1
`define PSS_ST_SLEEP 3'h2
`define PSS_ST_WAKE 3'h3
`define PSS_ST_ON 3'h4
// clock settle wait for oscillator and plls, in cycles
`define PSS_SETTLE_CYC 8'h10
// number of gated block clocks
`define PSS_NBLK 8
// retention memory depth and width
`define PSS_RET_DEPTH 16
`define PSS_RET_AW 4
`define PSS_RET_DW 8
`endif

// file: pss_chk.sv
// checker for the power state sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pss_chk (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic POWER_DOWN_PIN_N,
  input wire logic [2:0] POWER_STATE,
  input wire logic RTC_DOMAIN_EN,
  input wire logic MAIN_POWER_EN,
  input wire logic XTAL_EN,
  input wire logic PLL_EN,
  input wire logic HS_CLK_RUN,
  input wire logic [7:0] BLK_CLK_EN,
  input wire logic CPU_CLK_EN
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  wire logic [2:0] s = POWER_STATE; // state shorthand
  a_pin_off: assert property (!POWER_DOWN_PIN_N [*5] |-> s == 3'h0) else $error("pin");
  a_deep_main: assert property (s == 3'h1 |-> RTC_DOMAIN_EN && !MAIN_POWER_EN)
    else $error("deep");
  a_sleep_xtal: assert property (s == 3'h2 |-> MAIN_POWER_EN && !XTAL_EN) else $error("slp");
  a_wake_exit: assert property ($past(s) inside {3'h1, 3'h2} && s != $past(s)
    |-> s inside {3'h0, 3'h3}) else $error("exit");
  a_wake_osc: assert property (s == 3'h3 |-> XTAL_EN && !HS_CLK_RUN) else $error("osc");
  a_on_entry: assert property ($rose(s == 3'h4) |-> $past(s) == 3'h3) else $error("on");
  a_blk_off: assert property (s != 3'h4 |-> BLK_CLK_EN == 8'h00) else $error("blk");
  a_cpu_gate: assert property (CPU_CLK_EN |-> HS_CLK_RUN && s == 3'h4) else $error("cpu");
  a_pll_osc: assert property (PLL_EN == XTAL_EN) else $error("pll");
  a_off_dark: assert property (s == 3'h0 |-> !RTC_DOMAIN_EN && !MAIN_POWER_EN) else $error("off");
  c_deep: cover property (s == 3'h1);
  c_sleep: cover property (s == 3'h2);
  c_wait: cover property (s == 3'h4 && !CPU_CLK_EN);
endmodule // pss_chk
bind pss_power_state_sequencer pss_chk pss_chk_inst (.*);
`default_nettype wire

// file: pss_osc_model.sv
// oscillator and pll model: lock comes dly+1 cycles after enable
`timescale 1ns/1ps
`default_nettype none
module pss_osc_model (
  input wire logic clk,
  input wire logic en,
  input wire logic [3:0] dly,
  output logic lock
);
  logic [4:0] cnt_ff = 5'h00; // cycles since enable
  always @(posedge clk) cnt_ff <= en ? cnt_ff + 5'(cnt_ff <= 5'(dly)) : 5'h00;
  assign lock = en && cnt_ff > 5'(dly); // drops at once with enable
endmodule // pss_osc_model
`default_nettype wire

// file: pss_power_state_sequencer_test.sv
// bench for the power state sequencer
`timescale 1ns/1ps
`default_nettype none
module pss_power_state_sequencer_test;
  logic CORE_CLK = 0, RESET = 1, POWER_DOWN_PIN_N = 1, SLEEP_REQ = 0, DEEP_SLEEP_REQ = 0;
  logic WAIT_FOR_INTERRUPT_INSTR = 0, CPU_IRQ = 0, RET_WE = 0, CLOCKS_LOCKED, RTC_DOMAIN_EN;
  logic MAIN_POWER_EN, XTAL_EN, PLL_EN, HS_CLK_RUN, CPU_CLK_EN;
  logic [3:0] RET_ADDR = 0, dly = 0, wk = 0;
  logic [7:0] CLK_CTRL = 0, RET_WDATA = 0, RET_RDATA, BLK_CLK_EN;
  logic [2:0] POWER_STATE;
  logic [31:0] sd = 69;
  int num_errors = 0, num_checks = 0, cyc = 0;
  wire WAKE_MAC = wk[0], WAKE_HOST = wk[1], WAKE_RTC_TIMER = wk[2], WAKE_EXT_INT = wk[3];
  pss_power_state_sequencer pss_power_state_sequencer_inst (.*);
  pss_osc_model pss_osc_model_inst (.clk(CORE_CLK), .en(XTAL_EN), .dly(dly), .lock(CLOCKS_LOCKED));
  initial forever #50 CORE_CLK = ~CORE_CLK;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic [2:0] rest(input int i); // low power state of a round
    return i[0] ? 3'h1 : 3'h2;
  endfunction
  task automatic step(input int n); // drive just after the edge, cut hangs
    repeat (n) @(posedge CORE_CLK);
    #1 cyc += n;
    if (cyc > 5000) begin
      num_errors++;
      close_out;
    end
  endtask
  task automatic chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wst(input logic [2:0] e); // wait for a state
    for (int n = 0; n < 99 && POWER_STATE !== e; n++) step(1);
    chk(8'(POWER_STATE), 8'(e));
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    step(6);
    RESET = 0;
    wst(3'h4);
    chk(8'({XTAL_EN, PLL_EN}), 8'h03);
    sd = xs(sd);
    {RET_ADDR, RET_WDATA, CLK_CTRL, RET_WE} = {sd[19:0], 1'b1};
    step(1);
    RET_WE = 0;
    step(3);
    chk(BLK_CLK_EN, CLK_CTRL);
    WAIT_FOR_INTERRUPT_INSTR = 1;
    step(3);
    chk(8'({CPU_CLK_EN, HS_CLK_RUN}), 8'h01);
    CPU_IRQ = 1;
    step(3);
    chk(8'(CPU_CLK_EN), 8'h01);
    for (int i = 0; i < 4; i++) begin
      sd = xs(sd);
      dly = sd[3:0];
      {DEEP_SLEEP_REQ, SLEEP_REQ} = i[0] ? 2'h2 : 2'h1;
      wst(rest(i));
      {DEEP_SLEEP_REQ, SLEEP_REQ} = 2'h0;
      wk[i] = 1;
      wst(3'h3);
      wst(3'h4);
      wk = 0;
    end
    chk(RET_RDATA, RET_WDATA);
    POWER_DOWN_PIN_N = 0;
    wst(3'h0);
    step(4);
    chk(8'({RTC_DOMAIN_EN, MAIN_POWER_EN, PLL_EN}), 8'h00);
    POWER_DOWN_PIN_N = 1;
    wst(3'h4);
    chk(RET_RDATA, 8'h00);
    close_out;
  end
endmodule // pss_power_state_sequencer_test
`default_nettype wire
